// ### rtl/bit_cell_pkg.sv
// Package holding access kinds and reset values for the register bit cells
package bit_cell_pkg;

    typedef enum logic [3:0] {
        ACC_RW          = 4'h0,
        ACC_RO          = 4'h1,
        ACC_WO          = 4'h2,
        ACC_WC          = 4'h3,
        ACC_ANY_CLR     = 4'h4,
        ACC_RC          = 4'h5,
        ACC_LATCH_LOW   = 4'h6,
        ACC_LATCH_HIGH  = 4'h7,
        ACC_SELF_CLEAR  = 4'h8,
        ACC_SELF_SET    = 4'h9,
        ACC_STICKY_HIGH = 4'hA,
        ACC_RW_ANY_CLR  = 4'hB
    } access_t;

    localparam int  REG_WIDTH     = 16;
    localparam int  RESERVED_BITS = 3;
    localparam logic CELL_RESET   = 1'b0;
    localparam logic SET_RESET    = 1'b1;
    localparam logic [15:0] RD_RESET = 16'h0000;

    typedef enum logic [1:0] {
        ACT_IDLE = 2'b00,
        ACT_BUSY = 2'b01
    } act_state_t;

endpackage

// ### rtl/bit_cell.sv
// One register bit cell with a selectable access kind
`timescale 1ns/1ps
module bit_cell
#(
    parameter bit_cell_pkg::access_t ACCESS = bit_cell_pkg::ACC_RW,
    parameter logic    RST_VAL  = 1'b0,
    parameter bit      KEEP_SRST = 1'b0
) (
    // Clock and resets
    input  wire logic ref_clk,
    input  wire logic rstn,
    input  wire logic soft_rst,
    // Host strobes
    input  wire logic wr_stb,
    input  wire logic rd_stb,
    input  wire logic wr_bit,
    // Hardware side
    input  wire logic hw_cond,
    input  wire logic act_done,
    output logic      value,
    output logic      rd_bit
);
    import bit_cell_pkg::*;

    logic state_ff;
    logic nxt_state;
    wire  w_one = wr_stb & wr_bit;

    always_comb begin
        nxt_state = state_ff;
        case (ACCESS)
            ACC_RW:          if (wr_stb) nxt_state = wr_bit;
            ACC_RO:          nxt_state = hw_cond;
            ACC_WO:          if (wr_stb) nxt_state = wr_bit;
            ACC_WC:          nxt_state = hw_cond | (state_ff & ~w_one);
            ACC_ANY_CLR:     nxt_state = hw_cond | (state_ff & ~wr_stb);
            ACC_RW_ANY_CLR:  nxt_state = hw_cond | (state_ff & ~wr_stb);
            ACC_RC:          nxt_state = hw_cond | (state_ff & ~rd_stb);
            ACC_LATCH_LOW:   nxt_state = ~hw_cond | (state_ff & ~rd_stb);
            ACC_LATCH_HIGH:  nxt_state = hw_cond | (state_ff & ~rd_stb);
            ACC_STICKY_HIGH: nxt_state = hw_cond | (state_ff & ~rd_stb);
            ACC_SELF_CLEAR:  nxt_state = w_one | (state_ff & ~act_done);
            ACC_SELF_SET:    nxt_state = state_ff ? ~(wr_stb & ~wr_bit) : act_done;
            default:         nxt_state = state_ff;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            state_ff <= RST_VAL;
        end else if (soft_rst && !KEEP_SRST) begin
            state_ff <= RST_VAL;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Write-only data is not returned; reads show zero
    assign rd_bit = (ACCESS == ACC_WO) ? 1'b0 : state_ff;
    assign value  = state_ff;
endmodule

// ### rtl/register_bit_access_cells.sv
// Demonstration register built from the bit cell library
//
// Contract
// - A read-only bit follows hardware and ignores writes.
// - A write-only bit stores writes and returns unspecified (zero) data on reads.
// - A write-one-to-clear bit clears on a written one and keeps on a zero.
// - A write-anything-to-clear bit clears on any write to its register.
// - A read-to-clear bit returns its contents and clears after the read; writes ignored.
// - A latch-low bit captures a low condition and holds it until a register read.
// - A self-clearing bit set by writing one returns to zero after its action.
// - A self-setting bit once cleared returns to one by itself; written ones do nothing.
// - A latch-high status bit stays high until read even if the condition vanishes.
// - After that read the bit follows the condition, high if present, low if gone.
// - Bits kept over soft reset hold their value when soft reset is asserted.
// - A read/write bit stores the written value and returns it on reads.
// - A read/write-any-clear bit returns its value and clears on any write.
`timescale 1ns/1ps
module register_bit_access_cells
#(
    parameter int ACT_CYCLES = 4
) (
    // Clock and resets
    input  wire logic                               ref_clk,
    input  wire logic                               rstn,
    input  wire logic                               soft_rst,
    // Host strobes
    input  wire logic                               wr_stb,
    input  wire logic                               rd_stb,
    input  wire logic [bit_cell_pkg::REG_WIDTH-1:0] wr_data,
    output logic      [bit_cell_pkg::REG_WIDTH-1:0] rd_data,
    // Hardware conditions
    input  wire logic [bit_cell_pkg::REG_WIDTH-1:0] hw_cond,
    output logic      [bit_cell_pkg::REG_WIDTH-1:0] cell_value
);
    import bit_cell_pkg::*;

    localparam access_t KIND [REG_WIDTH] = '{
        ACC_RW, ACC_RO, ACC_WO, ACC_WC, ACC_ANY_CLR, ACC_RC, ACC_LATCH_LOW,
        ACC_LATCH_HIGH, ACC_SELF_CLEAR, ACC_SELF_SET, ACC_STICKY_HIGH,
        ACC_RW_ANY_CLR, ACC_RW, ACC_RO, ACC_RO, ACC_RO};

    // Self-setting cells wake up set, all others clear
    function automatic logic cell_rst_val(input access_t kind);
        return (kind == ACC_SELF_SET) ? SET_RESET : CELL_RESET;
    endfunction

    logic [REG_WIDTH-1:0] val_w;
    logic [REG_WIDTH-1:0] rd_w;
    logic [REG_WIDTH-1:0] rd_ff;
    logic [REG_WIDTH-1:0] val_ff;
    act_state_t           act_ff;
    act_state_t           nxt_act;
    logic [7:0]           cnt_ff;
    logic [7:0]           nxt_cnt;
    logic                 done_w;

    // Action timer shared by the self-clearing and self-setting bits
    wire start_w = (wr_stb & wr_data[8]) | (val_w[9] == 1'b0 && act_ff == ACT_IDLE);
    assign done_w  = (act_ff == ACT_BUSY) && (cnt_ff == 8'(ACT_CYCLES - 1));

    always_comb begin
        nxt_act = act_ff;
        nxt_cnt = cnt_ff;
        case (act_ff)
            ACT_IDLE: if (start_w) begin
                nxt_act = ACT_BUSY;
                nxt_cnt = 8'h00;
            end
            // Restart on a set at the done edge so the bit cannot stick high
            ACT_BUSY: if (done_w && start_w) begin
                nxt_cnt = 8'h00;
            end else if (done_w) begin
                nxt_act = ACT_IDLE;
            end else begin
                nxt_cnt = cnt_ff + 8'h01;
            end
            default: nxt_act = ACT_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            act_ff <= ACT_IDLE;
            cnt_ff <= 8'h00;
        end else begin
            act_ff <= nxt_act;
            cnt_ff <= nxt_cnt;
        end
    end

    genvar i;
    generate
        for (i = 0; i < REG_WIDTH; i++) begin : g_cell
            bit_cell #(
                .ACCESS   (KIND[i]),
                .RST_VAL  (cell_rst_val(KIND[i])),
                .KEEP_SRST(i == 12)
            ) u_cell (
                .ref_clk (ref_clk),
                .rstn    (rstn),
                .soft_rst(soft_rst),
                .wr_stb  (wr_stb),
                .rd_stb  (rd_stb),
                .wr_bit  (wr_data[i]),
                .hw_cond (hw_cond[i]),
                .act_done(done_w),
                .value   (val_w[i]),
                .rd_bit  (rd_w[i])
            );
        end
    endgenerate

    // Reserved top bits read as zero; software must not rely on them
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rd_ff  <= RD_RESET;
            val_ff <= RD_RESET;
        end else begin
            rd_ff  <= rd_stb ? {{RESERVED_BITS{1'b0}}, rd_w[REG_WIDTH-RESERVED_BITS-1:0]}
                             : rd_ff;
            val_ff <= val_w;
        end
    end

    assign rd_data    = rd_ff;
    assign cell_value = val_ff;

    // Multi-step behaviours
    sequence s_low_pulse;
        (!hw_cond[6] && !soft_rst) ##1 (hw_cond[6] && !rd_stb && !soft_rst);
    endsequence

    sequence s_high_pulse;
        (hw_cond[10] && !soft_rst) ##1 (!hw_cond[10] && !rd_stb && !soft_rst);
    endsequence

    sequence s_sc_arm;
        wr_stb && wr_data[8] && (act_ff == ACT_IDLE) && !soft_rst;
    endsequence

    a_rc_clears: assert property (@(posedge ref_clk) disable iff (!rstn)
        rd_stb && !hw_cond[5] && !soft_rst |=> !val_w[5])
        else $error("read-to-clear bit not cleared");

    a_wc_clear: assert property (@(posedge ref_clk) disable iff (!rstn)
        wr_stb && wr_data[3] && !hw_cond[3] && !soft_rst |=> !val_w[3])
        else $error("write-one-clear failed");

    a_wc_keep: assert property (@(posedge ref_clk) disable iff (!rstn)
        val_w[3] && !(wr_stb && wr_data[3]) && !soft_rst |=> val_w[3])
        else $error("write-one-clear bit lost");

    a_set_wins: assert property (@(posedge ref_clk) disable iff (!rstn)
        hw_cond[4] && !soft_rst |=> val_w[4])
        else $error("event lost against clear");

    a_sticky_hold: assert property (@(posedge ref_clk) disable iff (!rstn)
        val_w[10] && !rd_stb && !soft_rst |=> val_w[10])
        else $error("sticky high dropped before read");

    a_sticky_after: assert property (@(posedge ref_clk) disable iff (!rstn)
        rd_stb && !hw_cond[10] && !soft_rst |=> !val_w[10])
        else $error("sticky high kept after read");

    a_ro_ignore: assert property (@(posedge ref_clk) disable iff (!rstn)
        !soft_rst |=> val_w[1] == $past(hw_cond[1]))
        else $error("read-only bit not following hardware");

    a_rw_store: assert property (@(posedge ref_clk) disable iff (!rstn)
        wr_stb && !soft_rst |=> val_w[0] == $past(wr_data[0]))
        else $error("read-write bit not stored");

    a_keep_srst: assert property (@(posedge ref_clk) disable iff (!rstn)
        soft_rst && !wr_stb |=> $stable(val_w[12]))
        else $error("kept bit changed by soft reset");

    a_rd_capture: assert property (@(posedge ref_clk) disable iff (!rstn)
        rd_stb |=> (rd_data[12:3] == $past(val_w[12:3])) && (rd_data[1:0] == $past(val_w[1:0])))
        else $error("read data not captured from cells");

    a_wo_hidden: assert property (@(posedge ref_clk) disable iff (!rstn)
        rd_stb |=> !rd_data[2])
        else $error("write-only bit returned on read");

    a_rsvd_zero: assert property (@(posedge ref_clk) disable iff (!rstn)
        1'b1 |-> rd_data[15:13] == 3'b000)
        else $error("reserved read bits not zero");

    a_rd_hold: assert property (@(posedge ref_clk) disable iff (!rstn)
        !rd_stb |=> $stable(rd_data))
        else $error("read data moved without a read");

    a_wo_store: assert property (@(posedge ref_clk) disable iff (!rstn)
        wr_stb && !soft_rst |=> val_w[2] == $past(wr_data[2]))
        else $error("write-only bit not stored");

    a_wac_clear: assert property (@(posedge ref_clk) disable iff (!rstn)
        wr_stb && !hw_cond[4] && !soft_rst |=> !val_w[4])
        else $error("write-any-clear bit not cleared");

    a_wac_hold: assert property (@(posedge ref_clk) disable iff (!rstn)
        val_w[4] && !wr_stb && !soft_rst |=> val_w[4])
        else $error("write-any-clear bit lost");

    a_rwac_clear: assert property (@(posedge ref_clk) disable iff (!rstn)
        wr_stb && !hw_cond[11] && !soft_rst |=> !val_w[11])
        else $error("readable any-clear bit not cleared");

    a_rwac_hold: assert property (@(posedge ref_clk) disable iff (!rstn)
        val_w[11] && !wr_stb && !soft_rst |=> val_w[11])
        else $error("readable any-clear bit lost");

    a_rc_hold: assert property (@(posedge ref_clk) disable iff (!rstn)
        val_w[5] && !rd_stb && !soft_rst |=> val_w[5])
        else $error("read-to-clear bit lost without read");

    a_rc_set: assert property (@(posedge ref_clk) disable iff (!rstn)
        hw_cond[5] && !soft_rst |=> val_w[5])
        else $error("read-to-clear event lost");

    a_low_capture: assert property (@(posedge ref_clk) disable iff (!rstn)
        !hw_cond[6] && !soft_rst |=> val_w[6])
        else $error("low condition not captured");

    a_low_hold: assert property (@(posedge ref_clk) disable iff (!rstn)
        val_w[6] && !rd_stb && !soft_rst |=> val_w[6])
        else $error("latched low lost before read");

    a_low_release: assert property (@(posedge ref_clk) disable iff (!rstn)
        rd_stb && hw_cond[6] && !soft_rst |=> !val_w[6])
        else $error("latched low not released by read");

    a_low_pulse: assert property (@(posedge ref_clk) disable iff (!rstn)
        s_low_pulse |=> val_w[6])
        else $error("short low pulse not held");

    a_high_capture: assert property (@(posedge ref_clk) disable iff (!rstn)
        hw_cond[7] && !soft_rst |=> val_w[7])
        else $error("high condition not captured");

    a_high_hold: assert property (@(posedge ref_clk) disable iff (!rstn)
        val_w[7] && !rd_stb && !soft_rst |=> val_w[7])
        else $error("latched high lost before read");

    a_high_release: assert property (@(posedge ref_clk) disable iff (!rstn)
        rd_stb && !hw_cond[7] && !soft_rst |=> !val_w[7])
        else $error("latched high not released by read");

    a_sticky_keep: assert property (@(posedge ref_clk) disable iff (!rstn)
        rd_stb && hw_cond[10] && !soft_rst |=> val_w[10])
        else $error("sticky high dropped while present");

    a_sticky_pulse: assert property (@(posedge ref_clk) disable iff (!rstn)
        s_high_pulse |=> val_w[10])
        else $error("short high pulse not held");

    a_sc_set: assert property (@(posedge ref_clk) disable iff (!rstn)
        wr_stb && wr_data[8] && !soft_rst |=> val_w[8])
        else $error("self-clearing bit not set");

    a_sc_idle: assert property (@(posedge ref_clk) disable iff (!rstn)
        !val_w[8] && !(wr_stb && wr_data[8]) |=> !val_w[8])
        else $error("self-clearing bit set without a one");

    a_sc_done: assert property (@(posedge ref_clk) disable iff (!rstn)
        done_w && !(wr_stb && wr_data[8]) |=> !val_w[8])
        else $error("self-clearing bit not cleared");

    a_sc_start: assert property (@(posedge ref_clk) disable iff (!rstn)
        s_sc_arm |=> (act_ff == ACT_BUSY) && (cnt_ff == 8'h00))
        else $error("action timer not started");

    a_ss_clear: assert property (@(posedge ref_clk) disable iff (!rstn)
        val_w[9] && wr_stb && !wr_data[9] && !soft_rst |=> !val_w[9])
        else $error("self-setting bit not cleared");

    a_ss_keep: assert property (@(posedge ref_clk) disable iff (!rstn)
        val_w[9] && !(wr_stb && !wr_data[9]) |=> val_w[9])
        else $error("self-setting bit dropped");

    a_ss_ignore: assert property (@(posedge ref_clk) disable iff (!rstn)
        !val_w[9] && !done_w && !soft_rst |=> !val_w[9])
        else $error("self-setting bit set early");

    a_ss_done: assert property (@(posedge ref_clk) disable iff (!rstn)
        !val_w[9] && done_w |=> val_w[9])
        else $error("self-setting bit not set");

    a_ss_start: assert property (@(posedge ref_clk) disable iff (!rstn)
        !val_w[9] && (act_ff == ACT_IDLE) |=> act_ff == ACT_BUSY)
        else $error("self-setting timer not started");

    a_timer_bound: assert property (@(posedge ref_clk) disable iff (!rstn)
        (act_ff == ACT_BUSY) |-> cnt_ff < 8'(ACT_CYCLES))
        else $error("action timer overran");

    a_soft_clear: assert property (@(posedge ref_clk) disable iff (!rstn)
        soft_rst |=> !val_w[0])
        else $error("soft reset missed a plain bit");

    a_soft_set: assert property (@(posedge ref_clk) disable iff (!rstn)
        soft_rst |=> val_w[9])
        else $error("soft reset missed self-setting bit");

    a_rw_hold: assert property (@(posedge ref_clk) disable iff (!rstn)
        !wr_stb && !soft_rst |=> $stable(val_w[0]))
        else $error("read-write bit moved without write");

    a_copy_late: assert property (@(posedge ref_clk) disable iff (!rstn)
        1'b1 |=> cell_value == $past(val_w))
        else $error("cell copy not one cycle late");
endmodule

// ### verif/tb_top.sv
// Self-checking bench for the register bit cell demonstration block
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_errors++; \
    $display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end
module tb_top;
    import bit_cell_pkg::*;
    localparam int ACT = 4;
    logic        ref_clk  = 1'b0;
    logic        rstn     = 1'b0;
    logic        soft_rst = 1'b0;
    logic        wr_stb   = 1'b0;
    logic        rd_stb   = 1'b0;
    logic [15:0] wr_data  = 16'h0000;
    logic [15:0] hw_cond  = 16'h0040;
    logic [15:0] rd_data;
    logic [15:0] cell_value;
    logic        r1;
    int          n_errors    = 0;
    int          checks_done = 0;

    register_bit_access_cells #(.ACT_CYCLES(ACT)) dut (
        .ref_clk    (ref_clk),
        .rstn       (rstn),
        .soft_rst   (soft_rst),
        .wr_stb     (wr_stb),
        .rd_stb     (rd_stb),
        .wr_data    (wr_data),
        .rd_data    (rd_data),
        .hw_cond    (hw_cond),
        .cell_value (cell_value)
    );

    always #12.5 ref_clk = ~ref_clk;

    task step(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    // Upper reserved bits always go out as zero
    task wr(input logic [15:0] d);
        step(1); wr_stb = 1'b1; wr_data = d & 16'h1FFF;
        step(1); wr_stb = 1'b0;
    endtask
    // Bits 15..13 are never judged on reads
    task rd;
        step(1); rd_stb = 1'b1;
        step(1); rd_stb = 1'b0;
    endtask
    task wrap_up;
        if (n_errors == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Bit 9 is written as one in every write except the 16'h0000 write in t_self so that it is not cleared under other tests
    task t_rw_ro;
        hw_cond[1] = 1'b1;
        hw_cond[11] = 1'b1;
        step(1);
        hw_cond[11] = 1'b0;
        rd;
        `CHK(rd_data[11], 1'b1)
        `CHK(rd_data[1], 1'b1)
        wr(16'h0205);
        rd;
        `CHK(rd_data[0], 1'b1)
        `CHK(rd_data[1], 1'b1)
        `CHK(rd_data[2], 1'b0)
        `CHK(rd_data[11], 1'b0)
        `CHK(cell_value[2], 1'b1)
        wr(16'h0200);
        step(1);
        `CHK(cell_value[0], 1'b0)
        hw_cond[1] = 1'b0;
        step(2);
        `CHK(cell_value[1], 1'b0)
    endtask
    task t_clear;
        hw_cond[5:3] = 3'b111; step(1); hw_cond[5:3] = 3'b000; step(2);
        `CHK(cell_value[5:3], 3'b111)
        wr(16'h0200);
        step(1);
        `CHK(cell_value[5:3], 3'b101)
        wr(16'h0228);
        step(1);
        `CHK(cell_value[5:3], 3'b100)
        rd; `CHK(rd_data[5], 1'b1)
        step(1); `CHK(cell_value[5], 1'b0)
        hw_cond[5] = 1'b1; rd; step(1);
        `CHK(cell_value[5], 1'b1)
        hw_cond[5] = 1'b0;
    endtask
    task t_latch;
        rd; hw_cond[6] = 1'b0; step(1); hw_cond[6] = 1'b1;
        hw_cond[7] = 1'b1; hw_cond[10] = 1'b1; step(1);
        hw_cond[7] = 1'b0; hw_cond[10] = 1'b0; step(3);
        `CHK(cell_value[10], 1'b1)
        rd; r1 = rd_data[6];
        `CHK(rd_data[7], 1'b1)
        `CHK(rd_data[10], 1'b1)
        `CHK(r1, 1'b1)
        rd;
        `CHK(rd_data[6], 1'b0)
        `CHK(rd_data[7], 1'b0)
        `CHK(rd_data[10], 1'b0)
        hw_cond[10] = 1'b1; step(2); rd; rd;
        `CHK(rd_data[10], 1'b1)
        hw_cond[10] = 1'b0;
    endtask
    task t_self;
        wr(16'h0300);
        step(1);
        `CHK(cell_value[8], 1'b1)
        `CHK(cell_value[9], 1'b1)
        step(ACT - 1);
        `CHK(cell_value[8], 1'b1)
        step(2);
        `CHK(cell_value[8], 1'b0)
        wr(16'h0000);
        step(1);
        `CHK(cell_value[9], 1'b0)
        wr(16'h0200);
        step(1);
        `CHK(cell_value[9], 1'b0)
        step(ACT - 3);
        `CHK(cell_value[9], 1'b0)
        step(1);
        `CHK(cell_value[9], 1'b1)
    endtask
    task t_soft;
        wr(16'h1201);
        soft_rst = 1'b1;
        step(1);
        soft_rst = 1'b0;
        step(2);
        `CHK(cell_value[12], 1'b1)
        `CHK(cell_value[0], 1'b0)
        `CHK(cell_value[9], 1'b1)
        rd;
        `CHK(rd_data[12], 1'b1)
    endtask

    // Whole run takes about 72 cycles; this leaves ample margin
    initial begin
        #50000;
        n_errors++;
        $display("[ERR] %0t watchdog expired", $time);
        wrap_up;
    end

    initial begin
        step(4);
        rstn = 1'b1;
        step(1);
        `CHK(cell_value[11:0], 12'h200)
        t_rw_ro;
        t_clear;
        t_latch;
        t_self;
        t_soft;
        wrap_up;
    end
endmodule
